// *** vmexc_pkg.sv ***
package vmexc_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Core options
   localparam bit CORE_64 = 1'b1;
   localparam bit CAN_LOAD_PERF = 1'b1;
   localparam bit CAN_LOAD_PAT = 1'b1;
   localparam bit CAN_LOAD_EFER = 1'b1;

   // Host-state word indices (wide fields: low word even, high word odd)
   localparam int HS_SEL_CS = 0;
   localparam int HS_SEL_SS = 1;
   localparam int HS_SEL_DS = 2;
   localparam int HS_SEL_ES = 3;
   localparam int HS_SEL_FS = 4;
   localparam int HS_SEL_GS = 5;
   localparam int HS_SEL_TR = 6;
   localparam int HS_FC_CS = 7;
   localparam int HS_CR0 = 8;
   localparam int HS_CR3 = 10;
   localparam int HS_CR4 = 12;
   localparam int HS_SP = 14;
   localparam int HS_IP = 16;
   localparam int HS_BASE_FS = 18;
   localparam int HS_BASE_GS = 20;
   localparam int HS_BASE_TR = 22;
   localparam int HS_BASE_GDT = 24;
   localparam int HS_BASE_IDT = 26;
   localparam int HS_FC_SP = 28;
   localparam int HS_FC_IP = 30;
   localparam int HS_PERF = 32;
   localparam int HS_PAT = 34;
   localparam int HS_EFER = 36;
   localparam int HS_WORDS = 38;

   // Fixed-value components loaded after the host-state words
   localparam logic [5:0] LD_FIX_FLAGS = 6'h26;
   localparam logic [5:0] LD_FIX_DBGCTL = 6'h27;
   localparam logic [5:0] LD_LAST = 6'h27;
   localparam logic [31:0] FIX_FLAGS_VAL = 32'h00000002;
   localparam logic [31:0] FIX_DBGCTL_VAL = 32'h00000000;

   // Control register byte offsets
   localparam logic [7:0] OFF_PIN_CTL = 8'hA0;
   localparam logic [7:0] OFF_PROC_PRI = 8'hA4;
   localparam logic [7:0] OFF_PROC_SEC = 8'hA8;
   localparam logic [7:0] OFF_PIN_CAP_MUST1 = 8'hAC;
   localparam logic [7:0] OFF_PIN_CAP_MAY1 = 8'hB0;
   localparam logic [7:0] OFF_PIN_TRUE_MUST1 = 8'hB4;
   localparam logic [7:0] OFF_EXIT_CTL = 8'hB8;
   localparam logic [7:0] OFF_TIMER = 8'hBC;
   localparam logic [7:0] OFF_INTR_STATE = 8'hC0;
   localparam logic [7:0] OFF_STATUS = 8'hC4;
   localparam logic [7:0] OFF_CMD = 8'hC8;
   localparam logic [7:0] OFF_PIN_ACTIVE = 8'hCC;
   localparam logic [7:0] OFF_POSTED_VEC = 8'hD0;

   // Pin-event control bits
   localparam int PIN_EXT_EXIT = 0;
   localparam int PIN_NMI_EXIT = 3;
   localparam int PIN_VIRT_NMI = 5;
   localparam int PIN_TIMER = 6;
   localparam int PIN_POSTED = 7;
   localparam logic [31:0] PIN_RESET = 32'h00000016;
   localparam logic [31:0] PIN_MAY1 = 32'h000000FF;
   localparam logic [31:0] PIN_MUST1 = 32'h00000016;
   localparam logic [31:0] PIN_TRUE_MUST1 = 32'h00000000;

   // Exit control, status, command and interruptibility bits
   localparam int EXC_LOAD_PERF = 0;
   localparam int EXC_LOAD_PAT = 1;
   localparam int EXC_LOAD_EFER = 2;
   localparam logic [31:0] EXC_MAY1 = 32'h00000007;
   localparam int ST_IN_GUEST = 0;
   localparam int ST_ENTRY_FAIL = 1;
   localparam int CMD_ENTER = 0;
   localparam int INTR_NMI_BLOCK = 3;
   localparam logic [31:0] INTR_VALID = 32'h0000000F;
   localparam logic [7:0] NMI_DESCRIPTOR = 8'h02;

   // Exit reasons
   localparam logic [3:0] RSN_NONE = 4'h0;
   localparam logic [3:0] RSN_EXT_IRQ = 4'h1;
   localparam logic [3:0] RSN_NMI = 4'h2;
   localparam logic [3:0] RSN_TIMER = 4'h3;

   // Preemption timer tick: one decrement every 32 core cycles (TIMER_DIV_LAST + 1)
   localparam logic [4:0] TIMER_DIV_LAST = 5'h1F;

   function automatic logic [31:0] vmexc_hs_mask(input int idx);
      logic [31:0] m;
      m = 32'hFFFFFFFF;
      if (idx < HS_FC_CS) m = 32'h0000FFFF;
      else if (idx > HS_FC_CS && idx[0] && !CORE_64) m = 32'h00000000;
      if ((idx == HS_PERF || idx == HS_PERF + 1) && !CAN_LOAD_PERF) m = 32'h00000000;
      if ((idx == HS_PAT || idx == HS_PAT + 1) && !CAN_LOAD_PAT) m = 32'h00000000;
      if ((idx == HS_EFER || idx == HS_EFER + 1) && !CAN_LOAD_EFER) m = 32'h00000000;
      return m;
   endfunction : vmexc_hs_mask

endpackage : vmexc_pkg

// *** vmexc_top.sv ***
// Overview of operation
// RULE_01: Every exit walks the host-state words out on the load port.
// RULE_02: Control-register fields zero, three, four are 64 bits, 32 on narrow cores.
// RULE_03: Seven 16-bit selectors held; no local descriptor table selector.
// RULE_04: Bases of two extra segments, task and both tables are 64 bits.
// RULE_05: Fast-call code segment 32 bits; fast-call stack and entry 64 bits.
// RULE_06: Performance-control field exists only if its exit load is allowed.
// RULE_07: Attribute-table and feature-enable fields exist only if loadable.
// RULE_08: Exits also load fixed values for components without fields.
// RULE_09: Asynchronous event handling follows one 32-bit pin-event vector.
// RULE_10: Bit 0 set makes external interrupts exit, else guest delivery.
// RULE_11: With external exiting, the interrupt-enable flag does not block.
// RULE_12: Bit 3 set makes NMIs exit, else deliver through descriptor 2.
// RULE_13: Bit 5 set: NMIs never blocked; state bit 3 marks virtual blocking.
// RULE_14: Bit 6 set makes the preemption timer count down in guest.
// RULE_15: Timer reaching zero raises an exit at once.
// RULE_16: Bit 7 set records notification-vector interrupts as posted requests.
// RULE_17: Entry fails when reserved pin-event bits hold wrong values.
// RULE_18: Bits 1, 2, 4 reset to 1; basic report demands them as 1.
// RULE_19: Software unaware of a default-1 bit writes it as 1.
// RULE_20: Primary and secondary 32-bit instruction-event vectors are held.
// RULE_21: NMI or SMI delivery blocks NMIs until return-from-interrupt.
// RULE_22: Pin-event vector is sampled at entry and held until exit.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
module vmexc_top
   import vmexc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ext_irq_req,
   input wire logic [7:0] ext_irq_vector,
   input wire logic interrupt_enable_flag,
   input wire logic nmi_req,
   input wire logic smi_delivered,
   input wire logic return_from_interrupt,
   output logic ext_irq_ack,
   output logic irq_deliver,
   output logic nmi_deliver,
   output logic posted_record,
   output logic [7:0] deliver_vector,
   output logic exit_pulse,
   output logic [3:0] exit_reason,
   output logic host_load_valid,
   output logic [5:0] host_load_index,
   output logic [31:0] host_load_data,
   output logic in_guest,
   output logic entry_fail,
   output logic [31:0] proc_ctl_primary,
   output logic [31:0] proc_ctl_secondary
);

   typedef enum logic [1:0] {S_HOST, S_GUEST, S_LOAD} vmexc_state_t;

   logic rst_meta_reg;
   logic rst_sync_reg;
   logic wait_reg;
   logic [31:0] hs_mem [HS_WORDS];
   logic [31:0] hs_mask [HS_WORDS];
   logic [31:0] pin_reg;
   logic [31:0] pin_active_reg;
   logic [31:0] exc_reg;
   logic [31:0] timer_val_reg;
   logic [31:0] timer_reg;
   logic [4:0] div_reg;
   logic [31:0] intr_reg;
   logic [31:0] intr_next;
   logic [7:0] posted_vec_reg;
   logic nmi_pend_reg;
   logic fail_reg;
   vmexc_state_t state_reg;
   vmexc_state_t state_next;
   logic [5:0] load_cnt_reg;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Bus decode
   wire bus_req = avs_read | avs_write;
   wire wr_take = avs_write & ~wait_reg;
   wire rd_load = avs_read & wait_reg;
   wire [7:0] word_addr = {avs_address[7:2], 2'b00};
   wire [5:0] hs_idx = avs_address[7:2];
   wire hs_sel = (hs_idx < 6'(HS_WORDS));
   wire sel_pin = (word_addr == OFF_PIN_CTL);
   wire sel_pri = (word_addr == OFF_PROC_PRI);
   wire sel_sec = (word_addr == OFF_PROC_SEC);
   wire sel_exc = (word_addr == OFF_EXIT_CTL);
   wire sel_tmr = (word_addr == OFF_TIMER);
   wire sel_intr = (word_addr == OFF_INTR_STATE);
   wire sel_stat = (word_addr == OFF_STATUS);
   wire sel_cmd = (word_addr == OFF_CMD);
   wire sel_pvec = (word_addr == OFF_POSTED_VEC);
   wire host_wr = wr_take & (state_reg == S_HOST);

   // Answer one cycle after the request is seen
   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) wait_reg <= 1'b1;
      else wait_reg <= ~(bus_req & wait_reg);
   end

   // Host-state save area, one word per entry [RULE_02] [RULE_03] [RULE_04] [RULE_05]
   genvar gi;
   generate
      for (gi = 0; gi < HS_WORDS; gi++) begin : g_hs
         assign hs_mask[gi] = vmexc_hs_mask(gi); // [RULE_06] [RULE_07]
         always_ff @(posedge core_clk or negedge rst_sync_reg) begin
            if (!rst_sync_reg) hs_mem[gi] <= 32'h00000000;
            else if (wr_take && hs_idx == 6'(gi)) hs_mem[gi] <= avs_writedata & hs_mask[gi];
         end
      end
   endgenerate

   wire [31:0] hs_rd = hs_sel ? hs_mem[hs_idx] : 32'h00000000;
   wire [31:0] status_w = {30'h0, fail_reg, state_reg != S_HOST};
   wire [31:0] rd_word =
      hs_sel ? hs_rd :
      sel_pin ? pin_reg :
      sel_pri ? proc_ctl_primary :
      sel_sec ? proc_ctl_secondary :
      (word_addr == OFF_PIN_CAP_MUST1) ? PIN_MUST1 : // [RULE_18]
      (word_addr == OFF_PIN_CAP_MAY1) ? PIN_MAY1 :
      (word_addr == OFF_PIN_TRUE_MUST1) ? PIN_TRUE_MUST1 :
      sel_exc ? exc_reg :
      sel_tmr ? timer_val_reg :
      sel_intr ? intr_reg :
      sel_stat ? status_w :
      (word_addr == OFF_PIN_ACTIVE) ? pin_active_reg :
      sel_pvec ? {24'h0, posted_vec_reg} :
      32'h00000000;

   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) avs_readdata <= 32'h00000000;
      else if (rd_load) avs_readdata <= rd_word;
   end

   // Software-written controls
   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         pin_reg <= PIN_RESET; // [RULE_18] [RULE_09]
         proc_ctl_primary <= 32'h00000000; // [RULE_20]
         proc_ctl_secondary <= 32'h00000000;
         exc_reg <= 32'h00000000;
         timer_val_reg <= 32'h00000000;
         posted_vec_reg <= 8'h00;
      end else if (wr_take) begin
         if (sel_pin) pin_reg <= avs_writedata;
         if (sel_pri) proc_ctl_primary <= avs_writedata;
         if (sel_sec) proc_ctl_secondary <= avs_writedata;
         if (sel_exc) exc_reg <= avs_writedata & EXC_MAY1;
         if (sel_tmr) timer_val_reg <= avs_writedata;
         if (sel_pvec) posted_vec_reg <= avs_writedata[7:0];
      end
   end

   // Entry check against reserved settings [RULE_17]
   wire pin_ok = ((pin_reg & ~PIN_MAY1) == 32'h00000000)
                 && ((pin_reg & PIN_TRUE_MUST1) == PIN_TRUE_MUST1)
                 && ((intr_reg & ~INTR_VALID) == 32'h00000000);
   wire enter_req = host_wr & sel_cmd & avs_writedata[CMD_ENTER];
   wire enter_ok = enter_req & pin_ok;

   // Event decisions from the sampled copy
   wire guest = (state_reg == S_GUEST);
   wire ext_exit_en = pin_active_reg[PIN_EXT_EXIT];
   wire nmi_exit_en = pin_active_reg[PIN_NMI_EXIT];
   wire virt_nmi = pin_active_reg[PIN_VIRT_NMI];
   wire timer_en = pin_active_reg[PIN_TIMER];
   wire posted_en = pin_active_reg[PIN_POSTED];
   wire tick = (div_reg == TIMER_DIV_LAST);
   wire timer_zero = guest & timer_en & (timer_reg == 32'h00000000); // [RULE_15]
   wire nmi_blocked = intr_reg[INTR_NMI_BLOCK] & ~virt_nmi; // [RULE_13]
   wire nmi_take = guest & ~timer_zero & nmi_pend_reg & (nmi_exit_en | ~nmi_blocked);
   wire nmi_exit = nmi_take & nmi_exit_en; // [RULE_12]
   wire nmi_give = nmi_take & ~nmi_exit_en;
   wire irq_avail = guest & ~timer_zero & ~nmi_take & ext_irq_req & ~ext_irq_ack;
   wire irq_post = irq_avail & posted_en & (ext_irq_vector == posted_vec_reg); // [RULE_16]
   wire irq_exit = irq_avail & ~irq_post & ext_exit_en; // [RULE_10] [RULE_11]
   wire irq_give = irq_avail & ~irq_post & ~ext_exit_en & interrupt_enable_flag; // [RULE_10]
   wire do_exit = timer_zero | nmi_exit | irq_exit;
   wire [3:0] reason_w = timer_zero ? RSN_TIMER : nmi_exit ? RSN_NMI : RSN_EXT_IRQ;

   // Entry snapshot of the pin-event vector [RULE_22]
   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) pin_active_reg <= 32'h00000000;
      else if (enter_ok) pin_active_reg <= pin_reg;
   end

   // Preemption timer [RULE_14]
   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         div_reg <= 5'h00;
         timer_reg <= 32'h00000000;
      end else if (enter_ok) begin
         div_reg <= 5'h00;
         timer_reg <= timer_val_reg;
      end else if (guest && timer_en) begin
         div_reg <= div_reg + 5'h01;
         if (tick && timer_reg != 32'h00000000) timer_reg <= timer_reg - 32'h00000001;
      end
   end

   // Pending NMI; a new request wins over the take
   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) nmi_pend_reg <= 1'b0;
      else if (nmi_req) nmi_pend_reg <= 1'b1;
      else if (nmi_take) nmi_pend_reg <= 1'b0;
   end

   // Interruptibility state; hardware set beats clear and software write
   always_comb begin
      intr_next = intr_reg;
      if (host_wr && sel_intr) intr_next = avs_writedata;
      if (return_from_interrupt) intr_next[INTR_NMI_BLOCK] = 1'b0; // [RULE_21]
      if (nmi_give || smi_delivered) intr_next[INTR_NMI_BLOCK] = 1'b1; // [RULE_21] [RULE_13]
   end

   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) intr_reg <= 32'h00000000;
      else intr_reg <= intr_next;
   end

   // Entry failure flag, write 1 clears, set wins
   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) fail_reg <= 1'b0;
      else if (enter_req && !pin_ok) fail_reg <= 1'b1; // [RULE_17]
      else if (wr_take && sel_stat && avs_writedata[ST_ENTRY_FAIL]) fail_reg <= 1'b0;
   end

   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_HOST: if (enter_ok) state_next = S_GUEST;
         S_GUEST: if (do_exit) state_next = S_LOAD;
         S_LOAD: if (load_cnt_reg == LD_LAST) state_next = S_HOST;
         default: state_next = S_HOST;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         state_reg <= S_HOST;
         load_cnt_reg <= 6'h00;
      end else begin
         state_reg <= state_next;
         load_cnt_reg <= (state_reg == S_LOAD) ? load_cnt_reg + 6'h01 : 6'h00;
      end
   end

   // Host-state walk: field words, then fixed components
   wire load_hs = (load_cnt_reg < 6'(HS_WORDS));
   wire [31:0] load_mask = load_hs ? hs_mask[load_cnt_reg] : 32'hFFFFFFFF;
   wire perf_w = (load_cnt_reg[5:1] == 5'(HS_PERF / 2));
   wire pat_w = (load_cnt_reg[5:1] == 5'(HS_PAT / 2));
   wire efer_w = (load_cnt_reg[5:1] == 5'(HS_EFER / 2));
   wire load_gate = (load_mask != 32'h00000000)
                    && !(perf_w && !exc_reg[EXC_LOAD_PERF]) // [RULE_06]
                    && !(pat_w && !exc_reg[EXC_LOAD_PAT]) // [RULE_07]
                    && !(efer_w && !exc_reg[EXC_LOAD_EFER]);
   wire [31:0] load_word = load_hs ? hs_mem[load_cnt_reg] :
                           (load_cnt_reg == LD_FIX_FLAGS) ? FIX_FLAGS_VAL : // [RULE_08]
                           FIX_DBGCTL_VAL;

   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         host_load_valid <= 1'b0;
         host_load_index <= 6'h00;
         host_load_data <= 32'h00000000;
      end else begin
         host_load_valid <= (state_reg == S_LOAD) & load_gate; // [RULE_01]
         host_load_index <= load_cnt_reg;
         host_load_data <= load_word;
      end
   end

   // Event outputs
   always_ff @(posedge core_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         ext_irq_ack <= 1'b0;
         irq_deliver <= 1'b0;
         nmi_deliver <= 1'b0;
         posted_record <= 1'b0;
         deliver_vector <= 8'h00;
         exit_pulse <= 1'b0;
         exit_reason <= RSN_NONE;
         in_guest <= 1'b0;
         entry_fail <= 1'b0;
      end else begin
         ext_irq_ack <= irq_exit | irq_give | irq_post;
         irq_deliver <= irq_give;
         nmi_deliver <= nmi_give; // [RULE_12]
         posted_record <= irq_post; // [RULE_16]
         if (nmi_give) deliver_vector <= NMI_DESCRIPTOR;
         else if (irq_give || irq_post) deliver_vector <= ext_irq_vector;
         exit_pulse <= do_exit;
         if (do_exit) exit_reason <= reason_w;
         in_guest <= (state_next == S_GUEST);
         entry_fail <= fail_reg;
      end
   end

   assign avs_waitrequest = wait_reg;

endmodule : vmexc_top

// *** vmexc_top_assertions.sv ***
module vmexc_top_assertions
   import vmexc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [7:0] ext_irq_vector,
   input wire logic irq_deliver,
   input wire logic nmi_deliver,
   input wire logic posted_record,
   input wire logic [7:0] deliver_vector,
   input wire logic exit_pulse,
   input wire logic [3:0] exit_reason,
   input wire logic host_load_valid,
   input wire logic [5:0] host_load_index,
   input wire logic [31:0] host_load_data,
   input wire logic in_guest,
   input wire logic entry_fail
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   property p_bus_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("bus answer timing");
   property p_cap_must1;
      avs_read && !avs_waitrequest && avs_address == OFF_PIN_CAP_MUST1
         |-> avs_readdata == PIN_MUST1;
   endproperty
   a_cap_must1: assert property (p_cap_must1) else $error("basic must-1 report");
   property p_walk_start;
      exit_pulse |=> host_load_valid && host_load_index == 6'h00;
   endproperty
   a_walk_start: assert property (p_walk_start) else $error("load walk start");
   property p_walk_order;
      host_load_valid && $past(host_load_valid) |-> host_load_index > $past(host_load_index);
   endproperty
   a_walk_order: assert property (p_walk_order) else $error("load walk order");
   property p_out_of_guest;
      exit_pulse |-> (!in_guest)[*8];
   endproperty
   a_out_of_guest: assert property (p_out_of_guest) else $error("guest after exit");
   property p_fixed_flags;
      host_load_valid && host_load_index == LD_FIX_FLAGS |-> host_load_data == FIX_FLAGS_VAL;
   endproperty
   a_fixed_flags: assert property (p_fixed_flags) else $error("fixed flags value");
   property p_sel_width;
      host_load_valid && host_load_index < 6'h07 |-> host_load_data[31:16] == 16'h0000;
   endproperty
   a_sel_width: assert property (p_sel_width) else $error("selector width");
   property p_nmi_vec;
      nmi_deliver |-> deliver_vector == NMI_DESCRIPTOR;
   endproperty
   a_nmi_vec: assert property (p_nmi_vec) else $error("nmi descriptor");
   property p_irq_vec;
      irq_deliver |-> deliver_vector == $past(ext_irq_vector) && !exit_pulse && !posted_record;
   endproperty
   a_irq_vec: assert property (p_irq_vec) else $error("irq delivery");
   property p_fail_stays_host;
      $rose(entry_fail) |-> !in_guest;
   endproperty
   a_fail_stays_host: assert property (p_fail_stays_host) else $error("failed entry");
   c_timer_exit: cover property (exit_pulse && exit_reason == RSN_TIMER);
   c_nmi: cover property (nmi_deliver);
   c_posted: cover property (posted_record);
endmodule : vmexc_top_assertions

// *** test_vmexc_top.sv ***
`define CHK(nm, ex, got) \
   begin \
      n_tests++; \
      if ((got) !== (ex)) begin \
         fails++; \
         $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
      end \
   end

module test_vmexc_top;
   timeunit 1ns;
   timeprecision 100ps;
   import vmexc_pkg::*;
   logic core_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic ext_irq_req = 1'b0, interrupt_enable_flag = 1'b0, nmi_req = 1'b0;
   logic smi_delivered = 1'b0, return_from_interrupt = 1'b0;
   logic [7:0] avs_address = 8'h00, ext_irq_vector = 8'h00;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata, host_load_data, proc_ctl_primary, proc_ctl_secondary, rd;
   logic avs_waitrequest, ext_irq_ack, irq_deliver, nmi_deliver, posted_record, exit_pulse;
   logic host_load_valid, in_guest, entry_fail;
   logic [7:0] deliver_vector;
   logic [3:0] exit_reason;
   logic [5:0] host_load_index;
   logic [31:0] hs [0:39];
   int fails = 0, n_tests = 0, clk_n = 0, cyc, t0, t1;

   vmexc_top i_vmexc_top (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_irq_req(ext_irq_req), .ext_irq_vector(ext_irq_vector),
      .interrupt_enable_flag(interrupt_enable_flag), .nmi_req(nmi_req),
      .smi_delivered(smi_delivered), .return_from_interrupt(return_from_interrupt),
      .ext_irq_ack(ext_irq_ack), .irq_deliver(irq_deliver), .nmi_deliver(nmi_deliver),
      .posted_record(posted_record), .deliver_vector(deliver_vector),
      .exit_pulse(exit_pulse), .exit_reason(exit_reason), .host_load_valid(host_load_valid),
      .host_load_index(host_load_index), .host_load_data(host_load_data),
      .in_guest(in_guest), .entry_fail(entry_fail), .proc_ctl_primary(proc_ctl_primary),
      .proc_ctl_secondary(proc_ctl_secondary));

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) clk_n <= clk_n + 1;

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      `CHK("bus answer", 1'b0, avs_waitrequest)
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask : bus

   task automatic wait_hi(ref logic s, input int lim);
      cyc = 0;
      while (s !== 1'b1 && cyc < lim) begin
         @(posedge core_clk);
         cyc++;
      end
   endtask : wait_hi

   task automatic pulse(input bit nmi);
      nmi_req <= nmi;
      return_from_interrupt <= !nmi;
      @(posedge core_clk);
      nmi_req <= 1'b0;
      return_from_interrupt <= 1'b0;
   endtask : pulse

   task automatic enter(input logic [31:0] pin, input logic [31:0] tmr);
      bus(1'b1, OFF_TIMER, tmr);
      bus(1'b1, OFF_PIN_CTL, pin);
      bus(1'b1, OFF_CMD, 32'h00000001);
      t0 = clk_n;
      wait_hi(in_guest, 8);
      `CHK("guest", 1'b1, in_guest)
   endtask : enter

   task automatic exit_walk(input logic [3:0] rsn, input bit full);
      int i;
      wait_hi(exit_pulse, 700);
      t1 = clk_n;
      ext_irq_req <= 1'b0;
      `CHK("exit reason", rsn, exit_reason)
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         wait_hi(host_load_valid, 3);
         if (full) begin
            `CHK("load index", i[5:0], host_load_index)
            `CHK("load data", hs[i], host_load_data)
         end
      end
      @(posedge core_clk);
   endtask : exit_walk

   task automatic t_regs;
      int i;
      bus(1'b0, OFF_PIN_CTL, 32'h00000000);
      `CHK("pin reset", PIN_RESET, rd)
      bus(1'b0, OFF_PIN_CAP_MUST1, 32'h00000000);
      `CHK("basic must1", PIN_MUST1, rd)
      bus(1'b0, OFF_PIN_TRUE_MUST1, 32'h00000000);
      `CHK("true must1", PIN_TRUE_MUST1, rd)
      bus(1'b1, OFF_PROC_PRI, 32'hA5A55A5A);
      bus(1'b1, OFF_PROC_SEC, 32'h0F0F1234);
      `CHK("primary", 32'hA5A55A5A, proc_ctl_primary)
      `CHK("secondary", 32'h0F0F1234, proc_ctl_secondary)
      bus(1'b1, 8'hF0, 32'hFFFFFFFF);
      bus(1'b0, 8'hF0, 32'h00000000);
      `CHK("unmapped", 32'h00000000, rd)
      for (i = 0; i < HS_WORDS; i++) begin
         hs[i] = 32'hA5C30000 ^ (i * 32'h00010203);
         bus(1'b1, 8'(i * 4), hs[i]);
         if (i < HS_FC_CS) hs[i] = hs[i] & 32'h0000FFFF;
      end
      hs[38] = FIX_FLAGS_VAL;
      hs[39] = FIX_DBGCTL_VAL;
      bus(1'b0, 8'(HS_SEL_ES * 4), 32'h00000000);
      `CHK("selector", hs[HS_SEL_ES], rd)
      bus(1'b0, 8'(HS_CR0 * 4 + 4), 32'h00000000);
      `CHK("cr0 high", hs[HS_CR0 + 1], rd)
      bus(1'b0, 8'(HS_FC_CS * 4), 32'h00000000);
      `CHK("fast cs", hs[HS_FC_CS], rd)
      bus(1'b1, OFF_EXIT_CTL, EXC_MAY1);
   endtask : t_regs

   task automatic t_ext_exit;
      enter(PIN_RESET | 32'h00000001, 32'h00000000);
      bus(1'b1, OFF_PIN_CTL, PIN_RESET);
      bus(1'b0, OFF_PIN_ACTIVE, 32'h00000000);
      `CHK("active pin", PIN_RESET | 32'h00000001, rd)
      ext_irq_vector <= 8'h31;
      ext_irq_req <= 1'b1;
      exit_walk(RSN_EXT_IRQ, 1'b1);
   endtask : t_ext_exit

   task automatic t_guest_events;
      enter(PIN_RESET | 32'h00000040, 32'h00000010);
      ext_irq_vector <= 8'h44;
      ext_irq_req <= 1'b1;
      wait_hi(irq_deliver, 8);
      `CHK("held irq", 1'b0, irq_deliver)
      interrupt_enable_flag <= 1'b1;
      wait_hi(irq_deliver, 8);
      `CHK("irq deliver", 1'b1, irq_deliver)
      `CHK("irq vector", 8'h44, deliver_vector)
      `CHK("ack", 1'b1, ext_irq_ack)
      ext_irq_req <= 1'b0;
      pulse(1'b1);
      wait_hi(nmi_deliver, 8);
      `CHK("nmi vector", NMI_DESCRIPTOR, deliver_vector)
      bus(1'b0, OFF_INTR_STATE, 32'h00000000);
      `CHK("nmi block bit", 1'b1, rd[INTR_NMI_BLOCK])
      pulse(1'b1);
      wait_hi(nmi_deliver, 8);
      `CHK("blocked nmi", 1'b0, nmi_deliver)
      pulse(1'b0);
      wait_hi(nmi_deliver, 8);
      `CHK("nmi after return", 1'b1, nmi_deliver)
      interrupt_enable_flag <= 1'b0;
      exit_walk(RSN_TIMER, 1'b0);
      `CHK("timer span", 1'b1, (t1 - t0 >= 470 && t1 - t0 <= 560))
   endtask : t_guest_events

   task automatic t_nmi_modes;
      enter(PIN_RESET | 32'h00000008, 32'h00000000);
      pulse(1'b1);
      exit_walk(RSN_NMI, 1'b0);
      bus(1'b1, OFF_INTR_STATE, 32'h00000008);
      enter(PIN_RESET | 32'h00000060, 32'h00000002);
      pulse(1'b1);
      wait_hi(nmi_deliver, 8);
      `CHK("virtual nmi", 1'b1, nmi_deliver)
      exit_walk(RSN_TIMER, 1'b0);
   endtask : t_nmi_modes

   task automatic t_posted;
      bus(1'b1, OFF_POSTED_VEC, 32'h00000052);
      enter(PIN_RESET | 32'h000000C0, 32'h00000002);
      interrupt_enable_flag <= 1'b1;
      ext_irq_vector <= 8'h52;
      ext_irq_req <= 1'b1;
      wait_hi(posted_record, 8);
      `CHK("posted", 1'b1, posted_record)
      `CHK("posted not delivered", 1'b0, irq_deliver)
      ext_irq_req <= 1'b0;
      interrupt_enable_flag <= 1'b0;
      exit_walk(RSN_TIMER, 1'b0);
   endtask : t_posted

   task automatic t_fail;
      bus(1'b1, OFF_PIN_CTL, PIN_RESET | 32'h00000100);
      bus(1'b1, OFF_CMD, 32'h00000001);
      bus(1'b0, OFF_STATUS, 32'h00000000);
      `CHK("fail status", 2'b10, rd[1:0])
      `CHK("fail flag", 1'b1, entry_fail)
      bus(1'b1, OFF_STATUS, 32'h00000002);
      bus(1'b0, OFF_STATUS, 32'h00000000);
      `CHK("fail cleared", 1'b0, rd[1])
   endtask : t_fail

   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_regs;
      t_ext_exit;
      t_guest_events;
      t_nmi_modes;
      t_posted;
      t_fail;
      wrap_up;
   end

   initial begin
      #200000;
      fails++;
      wrap_up;
   end
endmodule : test_vmexc_top

bind vmexc_top vmexc_top_assertions i_vmexc_top_assertions (.core_clk(core_clk),
   .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .ext_irq_vector(ext_irq_vector), .irq_deliver(irq_deliver), .nmi_deliver(nmi_deliver),
   .posted_record(posted_record), .deliver_vector(deliver_vector), .exit_pulse(exit_pulse),
   .exit_reason(exit_reason), .host_load_valid(host_load_valid),
   .host_load_index(host_load_index), .host_load_data(host_load_data),
   .in_guest(in_guest), .entry_fail(entry_fail));
